// >>> timer_cfg.svh
// Offsets, field positions, reset values and divider settings of the carrier capable timer
// What this block does
// (R1) Run bit clear stops counting and holds counter at zero; set counts each count clock.
// (R2) Clock select codes pick peripheral clock /1,/4,/16,/64,/4096 or slow clock /128,/512,/1.
// (R3) Mode field: 00 interval, 01 carrier generator, 10 PWM; 11 must not be written.
// (R4) Output level bit gives the default output level: 0 low, 1 high.
// (R5) Output enable set in interval mode drives a 50% duty square wave; clear disables.
// (R6) Software leaves other mode bits alone while running; identical rewrites are fine.
// (R7) Software rewrites duty compare on every restart in PWM and carrier modes.
// (R8) Software keeps this count clock above six times the frame timer count clock.
// (R9) Carrier select and next level: x0 low, 01 high, 11 carrier from frame event edge.
// (R10) Read-only status bit 0 shows carrier output enabled (1) or disabled low (0).
// (R11) Software does not change carrier select while running; identical rewrites allowed.
// (R12) Reset clears mode and carrier control registers to 00h.
// (R13) Interval mode: counter equal to period compare raises interrupt and clears counter.
// (R14) Interval mode ignores duty compare entirely.
// (R15) Interval period is period compare plus one count clocks.
// (R16) Counter starts incrementing within one count clock after run is set; the code masks the first count clock and increments on the second.
// (R17) Each interval match clears counter and toggles output; interrupt on count clock edge.
// (R18) Clearing run returns interrupt and output to default levels.
// (R19) Software keeps period compare between 01h and feh for interval use.
// (R20) Software clears pin direction and pin latch bits to route the output.
// (R21) Carrier mode: period compare sets low width, duty compare sets high width.
// (R22) PWM: period match drives active, clears, interrupts; duty match drives inactive only.
// (R23) Duty writes while running wait in a latch, moved at the old duty match unless coincident.
// (R24) Carrier control bits 7 to 3 read zero and ignore writes.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define PERIOD_CMP_ADDR 16'hff1a
`define DUTY_CMP_ADDR 16'hff1b
`define MODE_CTRL_ADDR 16'hff6c
`define CARRIER_CTRL_ADDR 16'hff6d
`define MODE_CTRL_RESET 8'h00
`define CARRIER_CTRL_RESET 3'h0
`define CMP_RESET 8'h00
`define CARR_SEL_BIT 2
`define CARR_NEXT_BIT 1
`define DIV_SH_0 4'd0
`define DIV_SH_1 4'd2
`define DIV_SH_2 4'd4
`define DIV_SH_3 4'd6
`define DIV_SH_4 4'd12
`define SLOW_SH_5 4'd7
`define SLOW_SH_6 4'd9
`define SLOW_SH_7 4'd0
`endif

// >>> timer_pkg.sv
// Types shared by the carrier capable timer
package timer_pkg;
	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'h0,
		MODE_CARRIER = 2'h1,
		MODE_PWM = 2'h2,
		MODE_BAD = 2'h3
	} op_mode_t;
	typedef struct packed {
		logic run;
		logic [2:0] clk_sel;
		op_mode_t op_mode;
		logic default_out_level;
		logic out_enable_bit;
	} mode_ctrl_t;
	typedef struct packed {
		logic carrier_select_bit;
		logic next_level_bit;
		logic carrier_status_flag;
	} carrier_ctrl_t;
	// Which compare register the counter is matched against
	typedef enum logic [1:0] {
		CMP_PERIOD = 2'b01,
		CMP_DUTY = 2'b10
	} cmp_phase_t;
	typedef struct packed {
		logic [15:0] addr;
		logic wr_en;
		logic [7:0] wr_data;
	} cpu_req_t;
endpackage

// >>> carrier_capable_interval_timer.sv
// Eight-bit interval, PWM and carrier generator timer with its control registers
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module carrier_capable_interval_timer #(
	parameter int PRE_W = 12
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Processor register access
	input wire timer_pkg::cpu_req_t cpu_req,
	output var logic [7:0] rd_data,
	// Slow oscillator pin and frame timer event
	input wire logic slow_osc_in,
	input wire logic frame_timer_event,
	// Timer outputs
	output var logic timer_output_unit1,
	output var logic match_interrupt
);
	import timer_pkg::*;

	// Elaboration check: a narrower prescaler cannot reach the divide by 4096 tap
	if (PRE_W < 12) begin : pre_w_check
		$error("PRE_W must cover the divide by 4096 tap");
	end

	// True when the low sh bits of a free running count are zero
	function automatic logic tap(input logic [PRE_W-1:0] cnt, input logic [3:0] sh);
		logic [PRE_W-1:0] mask;
		mask = ~({PRE_W{1'b1}} << sh);
		return (cnt & mask) == '0;
	endfunction

	mode_ctrl_t mode_reg, mode_next;
	carrier_ctrl_t carr_reg, carr_next;
	cmp_phase_t phase_reg, phase_next;
	logic [7:0] period_reg, period_next, duty_reg, duty_next, buf_reg, buf_next;
	logic [7:0] cnt_reg, cnt_next, rd_next;
	logic pend_reg, pend_next, skip_reg, skip_next, out_reg, out_next, irq_next;
	logic [PRE_W-1:0] pre_reg, pre_next, slow_cnt_reg, slow_cnt_next;
	logic slow_s1_reg, slow_s2_reg, slow_s3_reg, evt_prev_reg;
	logic tick, slow_rise, evt_rise, step, wr_duty, match;

	// Next values of every register except the slow oscillator and frame event flops
	always_comb begin
		mode_next = mode_reg;
		carr_next = carr_reg;
		phase_next = phase_reg;
		period_next = period_reg;
		duty_next = duty_reg;
		buf_next = buf_reg;
		pend_next = pend_reg;
		cnt_next = cnt_reg;
		skip_next = skip_reg;
		out_next = out_reg;
		irq_next = 1'b0;
		match = 1'b0;
		pre_next = pre_reg + 1'b1;
		slow_rise = slow_s2_reg & ~slow_s3_reg;
		slow_cnt_next = slow_rise ? slow_cnt_reg + 1'b1 : slow_cnt_reg;
		evt_rise = frame_timer_event & ~evt_prev_reg;
		wr_duty = cpu_req.wr_en && cpu_req.addr == `DUTY_CMP_ADDR;
		// Count clock selection from the prescaler or slow oscillator
		unique case (mode_reg.clk_sel) // R2
			3'h0: tick = tap(pre_reg, `DIV_SH_0);
			3'h1: tick = tap(pre_reg, `DIV_SH_1);
			3'h2: tick = tap(pre_reg, `DIV_SH_2);
			3'h3: tick = tap(pre_reg, `DIV_SH_3);
			3'h4: tick = tap(pre_reg, `DIV_SH_4);
			3'h5: tick = slow_rise && tap(slow_cnt_reg, `SLOW_SH_5);
			3'h6: tick = slow_rise && tap(slow_cnt_reg, `SLOW_SH_6);
			3'h7: tick = slow_rise;
		endcase
		step = mode_reg.run && tick && !skip_reg;
		// Register writes
		if (cpu_req.wr_en && cpu_req.addr == `MODE_CTRL_ADDR)
			mode_next = mode_ctrl_t'(cpu_req.wr_data);
		if (cpu_req.wr_en && cpu_req.addr == `CARRIER_CTRL_ADDR) begin
			// Upper bits and the status bit are not writable
			carr_next.carrier_select_bit = cpu_req.wr_data[`CARR_SEL_BIT]; // R24
			carr_next.next_level_bit = cpu_req.wr_data[`CARR_NEXT_BIT];
		end
		if (cpu_req.wr_en && cpu_req.addr == `PERIOD_CMP_ADDR)
			period_next = cpu_req.wr_data;
		if (wr_duty && !mode_reg.run) begin
			duty_next = cpu_req.wr_data;
			pend_next = 1'b0;
		end else if (wr_duty) begin
			buf_next = cpu_req.wr_data; // R23
			pend_next = 1'b1;
		end
		// Frame event edge latches the next carrier level
		if (evt_rise)
			carr_next.carrier_status_flag = carr_reg.next_level_bit; // R9 R10
		// Counter and output
		if (!mode_reg.run) begin
			cnt_next = '0; // R1
			phase_next = CMP_PERIOD;
			skip_next = 1'b1;
			out_next = mode_reg.default_out_level; // R18 R4
		end else if (tick && skip_reg) begin
			// First count clock is masked after start
			skip_next = 1'b0; // R16
		end else if (step) begin
			unique case (mode_reg.op_mode) // R3
				MODE_INTERVAL: begin
					// Duty compare is never consulted here
					match = cnt_reg == period_reg; // R14 R15
					cnt_next = match ? 8'h00 : cnt_reg + 8'h01; // R13 R1
					irq_next = match; // R13 R17
					if (match)
						out_next = ~out_reg; // R17 R5
				end
				MODE_PWM: begin
					match = cnt_reg == (phase_reg == CMP_PERIOD ? period_reg : duty_reg);
					if (match && phase_reg == CMP_PERIOD) begin
						cnt_next = 8'h00; // R22
						irq_next = 1'b1;
						out_next = ~mode_reg.default_out_level;
						phase_next = CMP_DUTY;
					end else begin
						cnt_next = cnt_reg + 8'h01;
					end
					if (match && phase_reg == CMP_DUTY) begin
						out_next = mode_reg.default_out_level; // R22
						phase_next = CMP_PERIOD;
					end
				end
				default: begin
					// Carrier: low width from period, high width from duty
					match = cnt_reg == (phase_reg == CMP_PERIOD ? period_reg : duty_reg);
					cnt_next = match ? 8'h00 : cnt_reg + 8'h01; // R21
					irq_next = match;
					if (match)
						phase_next = phase_reg == CMP_PERIOD ? CMP_DUTY : CMP_PERIOD;
				end
			endcase
			// Pending duty moves on the old duty match, a coincident write keeps it waiting
			if (match && phase_reg == CMP_DUTY && pend_reg && !wr_duty) begin
				duty_next = buf_reg; // R23
				pend_next = 1'b0;
			end
		end
		// Carrier output is gated by the latched status
		if (mode_reg.run && mode_reg.op_mode == MODE_CARRIER)
			out_next = carr_next.carrier_status_flag
				&& (!carr_reg.carrier_select_bit || phase_next == CMP_DUTY); // R9
		if (!mode_reg.out_enable_bit)
			out_next = mode_reg.default_out_level; // R5
		// Read data, unmapped addresses read zero
		unique case (cpu_req.addr)
			`MODE_CTRL_ADDR: rd_next = mode_reg;
			`CARRIER_CTRL_ADDR: rd_next = {5'h00, carr_reg}; // R24
			`PERIOD_CMP_ADDR: rd_next = period_reg;
			`DUTY_CMP_ADDR: rd_next = duty_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// Register stage; the slow oscillator passes two flops before the edge detector
	always_ff @(posedge clock) begin
		slow_s1_reg <= slow_osc_in;
		slow_s2_reg <= slow_s1_reg;
		if (srst) begin
			mode_reg <= mode_ctrl_t'(`MODE_CTRL_RESET); // R12
			carr_reg <= carrier_ctrl_t'(`CARRIER_CTRL_RESET); // R12
			phase_reg <= CMP_PERIOD;
			period_reg <= `CMP_RESET;
			duty_reg <= `CMP_RESET;
			buf_reg <= `CMP_RESET;
			pend_reg <= 1'b0;
			cnt_reg <= 8'h00;
			skip_reg <= 1'b1;
			pre_reg <= '0;
			slow_cnt_reg <= '0;
			slow_s3_reg <= 1'b0;
			evt_prev_reg <= 1'b0;
			timer_output_unit1 <= 1'b0;
			match_interrupt <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			mode_reg <= mode_next;
			carr_reg <= carr_next;
			phase_reg <= phase_next;
			period_reg <= period_next;
			duty_reg <= duty_next;
			buf_reg <= buf_next;
			pend_reg <= pend_next;
			cnt_reg <= cnt_next;
			skip_reg <= skip_next;
			pre_reg <= pre_next;
			slow_cnt_reg <= slow_cnt_next;
			slow_s3_reg <= slow_s2_reg;
			evt_prev_reg <= frame_timer_event;
			timer_output_unit1 <= out_next;
			match_interrupt <= irq_next;
			rd_data <= rd_next;
		end
	end
	assign out_reg = timer_output_unit1;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	stop_holds_zero_a: assert property (!mode_reg.run |=> cnt_reg == 8'h00) // R1
		else $error("counter not held at zero while stopped");
	interval_match_a: assert property (step && mode_reg.op_mode == MODE_INTERVAL // R13
		&& cnt_reg == period_reg |=> match_interrupt && cnt_reg == 8'h00)
		else $error("interval match did not interrupt and clear");
	square_toggle_a: assert property (step && mode_reg.op_mode == MODE_INTERVAL // R17
		&& mode_reg.out_enable_bit && $stable(mode_reg) && cnt_reg == period_reg
		|=> timer_output_unit1 != $past(timer_output_unit1))
		else $error("square wave did not toggle on match");
	stop_default_a: assert property (!mode_reg.run |=> !match_interrupt // R18
		&& timer_output_unit1 == $past(mode_reg.default_out_level))
		else $error("stopped timer not at default levels");
	duty_unused_a: assert property (step && mode_reg.op_mode == MODE_INTERVAL // R14
		&& cnt_reg == duty_reg && cnt_reg != period_reg
		|=> !match_interrupt && cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("duty compare acted in interval mode");
	pwm_duty_a: assert property (step && mode_reg.op_mode == MODE_PWM // R22
		&& phase_reg == CMP_DUTY && cnt_reg == duty_reg |=> !match_interrupt
		&& cnt_reg == $past(cnt_reg) + 8'h01 && phase_reg == CMP_PERIOD)
		else $error("duty match cleared or interrupted");
	reset_regs_a: assert property (disable iff (1'b0) srst |=> // R12
		mode_reg == mode_ctrl_t'(8'h00) && carr_reg == carrier_ctrl_t'(3'h0))
		else $error("reset left control registers set");
	carr_upper_a: assert property (cpu_req.addr == `CARRIER_CTRL_ADDR |=> // R24
		rd_data[7:3] == 5'h00)
		else $error("carrier control upper bits not zero");
	status_latch_a: assert property (evt_rise |=> // R10
		carr_reg.carrier_status_flag == $past(carr_reg.next_level_bit))
		else $error("status flag missed frame event");
	start_count_a: assert property ($rose(mode_reg.run) && tick ##1 tick && mode_reg.run // R16
		##1 mode_reg.run |-> cnt_reg == 8'h01 || mode_reg.op_mode != MODE_INTERVAL
		|| period_reg == 8'h00)
		else $error("counter slow to start");
	interval_c: cover property (step && mode_reg.op_mode == MODE_INTERVAL && match);
	pwm_c: cover property (step && mode_reg.op_mode == MODE_PWM && phase_reg == CMP_DUTY && match);
	carrier_c: cover property (mode_reg.op_mode == MODE_CARRIER && evt_rise && carr_reg.carrier_select_bit);
	duty_move_c: cover property (pend_reg ##1 !pend_reg && mode_reg.run);
endmodule
`default_nettype wire

// >>> frame_timer_model.sv
// Frame timer stand-in that issues carrier gating events
`timescale 1ns/1ns
`default_nettype none
module frame_timer_model #(
	parameter int GAP = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bench request and event towards the timer
	input wire logic fire,
	output logic frame_timer_event
);
	int hold;
	// Event high three cycles; GAP spaces events as a slower count clock would
	always_ff @(posedge clock) begin
		if (srst) begin
			hold <= 0;
			frame_timer_event <= 1'b0;
		end else begin
			if (fire && hold == 0) hold <= GAP;
			else if (hold > 0) hold <= hold - 1;
			frame_timer_event <= (hold > GAP - 3);
		end
	end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the carrier capable timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_cfg.svh"
module tb;
	import timer_pkg::*;
	typedef struct {logic [15:0] a; logic [7:0] w, e;} row_t;
	logic clock, srst, slow_osc_in, fire, lv;
	cpu_req_t cpu_req;
	logic [7:0] rd_data;
	logic timer_output_unit1, match_interrupt, frame_timer_event;
	int failures, n_checks, g, h;
	int sh[5] = '{0, 2, 4, 6, 12};
	row_t rows[5] = '{'{16'hff1a, 8'h5a, 8'h5a}, '{16'hff1b, 8'h3c, 8'h3c},
		'{16'hff6c, 8'h76, 8'h76}, '{16'hff6d, 8'hff, 8'h06}, '{16'hff00, 8'h55, 8'h00}};
	// The output is watched as a pin routed to the timer would show it
	carrier_capable_interval_timer #(.PRE_W(12)) u_dut (.clock(clock), .srst(srst),
		.cpu_req(cpu_req), .rd_data(rd_data), .slow_osc_in(slow_osc_in),
		.frame_timer_event(frame_timer_event), .timer_output_unit1(timer_output_unit1),
		.match_interrupt(match_interrupt));
	frame_timer_model u_frame (.clock(clock), .srst(srst), .fire(fire),
		.frame_timer_event(frame_timer_event));
	// Clocks; slow oscillator period is exactly 34 clock periods
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	initial begin
		slow_osc_in = 0;
		forever #1700 slow_osc_in = ~slow_osc_in;
	end
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (!ok) begin
			failures++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	// Every task starts and ends 2 ns after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cpu_req = '{addr: a, wr_en: 1'b1, wr_data: d};
		step(1);
		cpu_req.wr_en = 1'b0;
		// One idle edge keeps back to back strobes apart and lets the write act
		step(1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string m);
		cpu_req.addr = a;
		step(1);
		chk(rd_data === e, m);
	endtask
	// Cycles from one interrupt pulse to the next, bounded
	task automatic gap(output int n);
		int k;
		k = 0;
		while (match_interrupt !== 1'b1 && k < 25000) begin
			step(1);
			k++;
		end
		n = 0;
		do begin
			step(1);
			n++;
		end while (match_interrupt !== 1'b1 && n < 25000);
		// A pulse that never comes is a mismatch, not a silent short count
		if (k >= 25000 || n >= 25000) chk(1'b0, "no interrupt");
	endtask
	task automatic hi_cnt(input int c, output int n);
		n = 0;
		repeat (c) begin
			if (timer_output_unit1 === 1'b1) n++;
			step(1);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		failures = 0;
		n_checks = 0;
		fire = 0;
		srst = 1;
		cpu_req = '0;
		repeat (12) @(posedge clock);
		#2;
		srst = 0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e, "readback");
		end
		// Second reset must clear what the rows left behind
		srst = 1;
		step(1);
		srst = 0;
		rd(`MODE_CTRL_ADDR, 8'h00, "mode reset");
		rd(`CARRIER_CTRL_ADDR, 8'h00, "carrier reset");
		chk(timer_output_unit1 === 1'b0 && match_interrupt === 1'b0, "idle");
		// Interval, period 3; duty 1 would clear early if it were not ignored
		wr(`PERIOD_CMP_ADDR, 8'h03);
		wr(`DUTY_CMP_ADDR, 8'h01);
		for (int c = 0; c < 5; c++) begin
			wr(`MODE_CTRL_ADDR, {1'b0, c[2:0], 4'b0001});
			wr(`MODE_CTRL_ADDR, {1'b1, c[2:0], 4'b0001});
			gap(g);
			chk(g == (4 << sh[c]), "interval period");
			if (c == 0) begin
				lv = timer_output_unit1;
				gap(g);
				chk(timer_output_unit1 === ~lv, "square wave");
			end
			wr(`MODE_CTRL_ADDR, {1'b0, c[2:0], 4'b0001});
			chk(timer_output_unit1 === 1'b0 && match_interrupt === 1'b0, "stop");
		end
		// Slow oscillator undivided: it rises every 34 clocks, four rises per interval
		wr(`MODE_CTRL_ADDR, 8'h71);
		wr(`MODE_CTRL_ADDR, 8'hf1);
		gap(g);
		chk(g == 4 * 34, "slow clock period");
		wr(`MODE_CTRL_ADDR, 8'h71);
		chk(timer_output_unit1 === 1'b0, "slow stop");
		wr(`MODE_CTRL_ADDR, 8'h03);
		chk(timer_output_unit1 === 1'b1, "default high");
		// PWM period 5 duty 2, then a duty change while running
		wr(`PERIOD_CMP_ADDR, 8'h05);
		wr(`MODE_CTRL_ADDR, 8'h09);
		wr(`DUTY_CMP_ADDR, 8'h02);
		wr(`MODE_CTRL_ADDR, 8'h89);
		gap(g);
		chk(g == 6, "pwm period");
		hi_cnt(6, h);
		chk(h == 3, "pwm duty");
		wr(`DUTY_CMP_ADDR, 8'h03);
		gap(g);
		gap(g);
		hi_cnt(6, h);
		chk(h == 4, "duty latch");
		wr(`MODE_CTRL_ADDR, 8'h09);
		chk(timer_output_unit1 === 1'b0, "pwm stop");
		// Carrier low width 4, high width 2, gated by frame events
		wr(`PERIOD_CMP_ADDR, 8'h03);
		wr(`MODE_CTRL_ADDR, 8'h05);
		wr(`CARRIER_CTRL_ADDR, 8'h06);
		wr(`DUTY_CMP_ADDR, 8'h01);
		wr(`MODE_CTRL_ADDR, 8'h85);
		fire = 1;
		step(1);
		fire = 0;
		step(4);
		rd(`CARRIER_CTRL_ADDR, 8'h07, "status on");
		gap(g);
		chk(g == 4, "carrier low width");
		hi_cnt(18, h);
		chk(h == 6, "carrier widths");
		wr(`CARRIER_CTRL_ADDR, 8'h04);
		fire = 1;
		step(1);
		fire = 0;
		step(4);
		rd(`CARRIER_CTRL_ADDR, 8'h04, "status off");
		hi_cnt(12, h);
		chk(h == 0, "carrier low");
		wr(`MODE_CTRL_ADDR, 8'h05);
		complete_run;
	end
	// Watchdog well beyond the longest divider run
	initial begin
		#8000000;
		failures++;
		complete_run;
	end
endmodule
`default_nettype wire
